// ---- shared/hopi_consts.vh ----
// constants of the high-order pointer interpreter: register offsets,
// configuration fields, reset values, state codes and pointer figures
// assumes inclusion by bare name from the design file, 100 MHz clock
`ifndef HOPI_CONSTS_VH
`define HOPI_CONSTS_VH

// register byte offsets
`define HOPI_CFG_OFS      8'h00
`define HOPI_CONCATENATED_STATE_LO_OFS  8'h04
`define HOPI_CONCATENATED_STATE_HI_OFS  8'h08
`define HOPI_SEL_OFS      8'h0c
`define HOPI_STAT_OFS     8'h10

// configuration fields and reset value
`define HOPI_CFG_SDH      0
`define HOPI_CFG_SS_DIS   1
`define HOPI_CFG_SEP_DIS  2
`define HOPI_CFG_RNG_DIS  3
`define HOPI_CFG_INV_CLR  4
`define HOPI_CFG_LOP_AIS  5
`define HOPI_CFG_RDI_REQ  6
`define HOPI_CFG_INBAND   7
`define HOPI_CFG_CONCATENATED_STATE_AIS 8
`define HOPI_CFG_W        9
`define HOPI_CFG_RST      9'h000

// slot count and pointer figures
`define HOPI_SLOTS        48
`define HOPI_OFS_MAX      10'h30e
`define HOPI_CONCATENATED_STATE_OFS     10'h3ff
`define HOPI_SS_SDH       2'h2
`define HOPI_SEP_FRAMES   3'h3
`define HOPI_AIS_CNT      2'h2
`define HOPI_EQ_CNT       2'h2
`define HOPI_INV_CNT      3'h7
`define HOPI_NDF_CNT      3'h7

// state codes, shared by both machines
`define HOPI_ST_NORMAL_STATE      2'h0
`define HOPI_ST_AIS       2'h1
`define HOPI_ST_LOP       2'h2

`endif

// ---- rtl/hopi_core.v ----
// high-order pointer interpreter: per-slot pointer and concatenation
// state machines with a classic wishbone register slave
// assumes one H1/H2 pair per slot per frame from the aligned upstream
//
// Added by the designer: the Wishbone register port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
`include "hopi_consts.vh"

module hopi_core
(
    // clock and reset
    input  wire        clk_i,
    input  wire        rst_i,
    // wishbone slave
    input  wire        wb_cyc_i,
    input  wire        wb_stb_i,
    input  wire        wb_we_i,
    input  wire [7:0]  wb_adr_i,
    input  wire [3:0]  wb_sel_i,
    input  wire [31:0] wb_dat_i,
    output reg  [31:0] wb_dat_o,
    output reg         wb_ack_o,
    // pointer bytes from the section/line processor
    input  wire        ptr_valid_i,
    input  wire [5:0]  ptr_slot_i,
    input  wire [7:0]  ptr_h1_i,
    input  wire [7:0]  ptr_h2_i,
    // per-pointer result, ring port and drop bus controls
    output reg         res_valid_o,
    output reg  [5:0]  res_slot_o,
    output reg  [1:0]  res_state_o,
    output reg         res_concatenated_state_o,
    output reg  [9:0]  res_offset_o,
    output reg         res_inc_o,
    output reg         res_dec_o,
    output reg         lop_decl_o,
    output reg         path_alarm_declared_decl_o,
    output reg         drop_ais_o,
    output reg         rdi_req_o,
    output reg         g1_rdi_o
);

    // configuration and provisioning registers
    reg  [`HOPI_CFG_W-1:0] cfg_reg;          // option bits
    reg  [31:0]            concatenated_state_lo_reg;      // slots 0..31 concatenated
    reg  [15:0]            concatenated_state_hi_reg;      // slots 32..47 concatenated
    reg  [5:0]             sel_reg;          // slot shown in status

    // per-slot storage, indexed by slot
    reg  [1:0]             st_mem  [0:`HOPI_SLOTS-1]; // machine state
    reg  [9:0]             act_mem [0:`HOPI_SLOTS-1]; // active offset
    reg  [9:0]             pend_mem[0:`HOPI_SLOTS-1]; // candidate offset
    reg  [2:0]             inv_mem [0:`HOPI_SLOTS-1]; // invalid run
    reg  [2:0]             ndf_mem [0:`HOPI_SLOTS-1]; // flag run
    reg  [1:0]             ais_mem [0:`HOPI_SLOTS-1]; // all-ones run
    reg  [1:0]             eq_mem  [0:`HOPI_SLOTS-1]; // equal new run
    reg  [2:0]             age_mem [0:`HOPI_SLOTS-1]; // frames since just

    integer                i;                // slot index for reset
    integer                j;                // byte lane index for writes

    // current slot view
    wire                   slot_ok  = (ptr_slot_i < 6'd48);
    wire [5:0]             s        = slot_ok ? ptr_slot_i : 6'h00;
    wire [47:0]            concatenated_state_map = {concatenated_state_hi_reg, concatenated_state_lo_reg};
    wire                   concatenated_state     = concatenated_state_map[s];
    wire [1:0]             st       = st_mem[s];
    wire [9:0]             act      = act_mem[s];
    wire [9:0]             pend     = pend_mem[s];
    wire [2:0]             inv_c    = inv_mem[s];
    wire [2:0]             ndf_c    = ndf_mem[s];
    wire [1:0]             ais_c    = ais_mem[s];
    wire [1:0]             eq_c     = eq_mem[s];
    wire [2:0]             age      = age_mem[s];

    // pointer fields
    wire [3:0]             flag     = ptr_h1_i[7:4];
    wire [1:0]             ss       = ptr_h1_i[3:2];
    wire [9:0]             ofs      = {ptr_h1_i[1:0], ptr_h2_i};

    // flag decode, five codes each way, six left invalid
    reg                    flag_en;
    reg                    flag_dis;
    always @*
    begin
        flag_en  = 1'b0;
        flag_dis = 1'b0;
        case (flag)
            4'h9, 4'h1, 4'hd, 4'hb, 4'h8: flag_en  = 1'b1;
            4'h6, 4'he, 4'h2, 4'h4, 4'h7: flag_dis = 1'b1;
            default:                      flag_en  = 1'b0;
        endcase
    end

    // size bits checked only in SDH, unless switched off
    wire ss_ok = cfg_reg[`HOPI_CFG_SS_DIS] | ~cfg_reg[`HOPI_CFG_SDH] |
                 (ss == `HOPI_SS_SDH);
    wire in_rng   = (ofs <= `HOPI_OFS_MAX);
    wire all_ones = (ptr_h1_i == 8'hff) & (ptr_h2_i == 8'hff);

    // majority voting on inverted I (odd) and D (even) bits
    wire [9:0] flip  = ofs ^ act;
    wire [2:0] i_sum = {2'b00, flip[9]} + {2'b00, flip[7]} +
                       {2'b00, flip[5]} + {2'b00, flip[3]} +
                       {2'b00, flip[1]};
    wire [2:0] d_sum = {2'b00, flip[8]} + {2'b00, flip[6]} +
                       {2'b00, flip[4]} + {2'b00, flip[2]} +
                       {2'b00, flip[0]};
    wire i_maj  = (i_sum >= 3'h3);
    wire d_maj  = (d_sum >= 3'h3);
    wire sep_ok = cfg_reg[`HOPI_CFG_SEP_DIS] |
                  (age > `HOPI_SEP_FRAMES);

    // indications of the pointer machine
    wire normal_state_ind = flag_dis & ss_ok & (ofs == act);
    wire ndf_ind  = flag_en & ss_ok & in_rng;
    wire ndf_lop  = flag_en & ss_ok &
                    (in_rng | cfg_reg[`HOPI_CFG_RNG_DIS]);
    wire increment_indication  = flag_dis & ss_ok & i_maj & ~d_maj & sep_ok;
    wire decrement_indication  = flag_dis & ss_ok & d_maj & ~i_maj & sep_ok;
    wire new_ind  = flag_dis & ss_ok & in_rng & (ofs != act);
    // increments and decrements stay valid even out of range
    wire inv_ind  = ~(normal_state_ind | ndf_ind | all_ones | increment_indication | decrement_indication)
                    | new_ind;
    wire eq_new   = new_ind & (eq_c != 2'h0) & (ofs == pend);

    // indications of the concatenation machine, size bits ignored
    wire concatenation_indication = flag_en & (ofs == `HOPI_CONCATENATED_STATE_OFS);
    wire cinv_ind = ~concatenation_indication & ~all_ones;

    // next state of the addressed slot
    reg  [1:0] st_n;
    reg  [9:0] act_n;
    reg  [9:0] pend_n;
    reg  [2:0] inv_n;
    reg  [2:0] ndf_n;
    reg  [1:0] ais_n;
    reg  [1:0] eq_n;
    reg  [2:0] age_n;
    reg        inc_n;
    reg        dec_n;
    always @*
    begin
        st_n   = st;
        act_n  = act;
        pend_n = pend;
        inc_n  = 1'b0;
        dec_n  = 1'b0;
        age_n  = (age > `HOPI_SEP_FRAMES) ? age : age + 3'h1;
        if (concatenated_state)
        begin
            // consecutive runs for the concatenation machine
            inv_n  = cinv_ind ? ((inv_c == 3'h7) ? inv_c : inv_c + 3'h1)
                              : 3'h0;
            ais_n  = all_ones ? ((ais_c == 2'h3) ? ais_c : ais_c + 2'h1)
                              : 2'h0;
            eq_n   = concatenation_indication ? ((eq_c == 2'h3) ? eq_c : eq_c + 2'h1)
                              : 2'h0;
            ndf_n  = 3'h0;
            case (st)
                `HOPI_ST_NORMAL_STATE:
                begin
                    if (all_ones && ais_c == `HOPI_AIS_CNT)
                        st_n = `HOPI_ST_AIS;
                    else if (cinv_ind && inv_c == `HOPI_INV_CNT)
                        st_n = `HOPI_ST_LOP;
                end
                `HOPI_ST_AIS:
                begin
                    if (concatenation_indication && eq_c == `HOPI_EQ_CNT)
                        st_n = `HOPI_ST_NORMAL_STATE;
                    else if (cinv_ind && inv_c == `HOPI_INV_CNT)
                        st_n = `HOPI_ST_LOP;
                end
                `HOPI_ST_LOP:
                begin
                    if (concatenation_indication && eq_c == `HOPI_EQ_CNT)
                        st_n = `HOPI_ST_NORMAL_STATE;
                    else if (all_ones && ais_c == `HOPI_AIS_CNT)
                        st_n = `HOPI_ST_AIS;
                end
                default: st_n = `HOPI_ST_LOP;
            endcase
        end
        else
        begin
            // consecutive runs for the pointer machine
            inv_n  = inv_ind ? ((inv_c == 3'h7) ? inv_c : inv_c + 3'h1)
                             : 3'h0;
            ndf_n  = ndf_lop ? ((ndf_c == 3'h7) ? ndf_c : ndf_c + 3'h1)
                             : 3'h0;
            ais_n  = all_ones ? ((ais_c == 2'h3) ? ais_c : ais_c + 2'h1)
                              : 2'h0;
            eq_n   = new_ind ? (eq_new ? ((eq_c == 2'h3) ? eq_c
                                                         : eq_c + 2'h1)
                                       : 2'h1)
                             : 2'h0;
            if (new_ind)
                pend_n = ofs;
            if (ndf_ind | increment_indication | decrement_indication)
                age_n = 3'h0;
            if (eq_new && eq_c == `HOPI_EQ_CNT)
            begin
                // three equal new pointers override everything
                st_n  = `HOPI_ST_NORMAL_STATE;
                act_n = ofs;
                if (cfg_reg[`HOPI_CFG_INV_CLR])
                    inv_n = 3'h0;
            end
            else
            begin
                case (st)
                    `HOPI_ST_NORMAL_STATE:
                    begin
                        if (all_ones && ais_c == `HOPI_AIS_CNT)
                            st_n = `HOPI_ST_AIS;
                        else if ((inv_ind && inv_c == `HOPI_INV_CNT) ||
                                 (ndf_lop && ndf_c == `HOPI_NDF_CNT))
                            st_n = `HOPI_ST_LOP;
                        else if (ndf_ind)
                            act_n = ofs;
                        else if (increment_indication)
                        begin
                            // step forward, wrap past the last offset
                            act_n = (act >= `HOPI_OFS_MAX) ? 10'h000
                                                            : act + 10'h001;
                            inc_n = 1'b1;
                        end
                        else if (decrement_indication)
                        begin
                            // step back, wrap below zero
                            act_n = (act == 10'h000) ? `HOPI_OFS_MAX
                                                     : act - 10'h001;
                            dec_n = 1'b1;
                        end
                    end
                    `HOPI_ST_AIS:
                    begin
                        if (ndf_ind)
                        begin
                            st_n  = `HOPI_ST_NORMAL_STATE;
                            act_n = ofs;
                        end
                        else if (inv_ind && inv_c == `HOPI_INV_CNT)
                            st_n = `HOPI_ST_LOP;
                    end
                    `HOPI_ST_LOP:
                    begin
                        if (all_ones && ais_c == `HOPI_AIS_CNT)
                            st_n = `HOPI_ST_AIS;
                    end
                    default: st_n = `HOPI_ST_LOP;
                endcase
            end
        end
        // the flag, all-ones and equal-new runs restart on a change
        if (st_n != st)
        begin
            ndf_n = 3'h0;
            ais_n = 2'h0;
            eq_n  = 2'h0;
        end
    end

    // entry into the alarm states
    wire enter_lop  = (st_n == `HOPI_ST_LOP) & (st != `HOPI_ST_LOP);
    wire enter_ais  = (st_n == `HOPI_ST_AIS) & (st != `HOPI_ST_AIS);
    wire in_alarm   = (st_n != `HOPI_ST_NORMAL_STATE);
    // AIS always inserted in path alarm of a pointer slot, optional in loss and in concatenated slots
    wire ais_insert = concatenated_state ? (in_alarm & cfg_reg[`HOPI_CFG_CONCATENATED_STATE_AIS])
                           : ((st_n == `HOPI_ST_AIS) |
                              ((st_n == `HOPI_ST_LOP) &
                               cfg_reg[`HOPI_CFG_LOP_AIS]));

    // per-slot storage update, one pointer per slot per frame
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            for (i = 0; i < `HOPI_SLOTS; i = i + 1)
            begin
                st_mem[i]   <= `HOPI_ST_LOP;
                act_mem[i]  <= 10'h000;
                pend_mem[i] <= 10'h000;
                inv_mem[i]  <= 3'h0;
                ndf_mem[i]  <= 3'h0;
                ais_mem[i]  <= 2'h0;
                eq_mem[i]   <= 2'h0;
                age_mem[i]  <= 3'h4;
            end
        end
        else if (ptr_valid_i && slot_ok)
        begin
            st_mem[s]   <= st_n;
            act_mem[s]  <= act_n;
            pend_mem[s] <= pend_n;
            inv_mem[s]  <= inv_n;
            ndf_mem[s]  <= ndf_n;
            ais_mem[s]  <= ais_n;
            eq_mem[s]   <= eq_n;
            age_mem[s]  <= age_n;
        end
    end

    // result and alarm reporting outputs
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            res_valid_o  <= 1'b0;
            res_slot_o   <= 6'h00;
            res_state_o  <= `HOPI_ST_LOP;
            res_concatenated_state_o   <= 1'b0;
            res_offset_o <= 10'h000;
            res_inc_o    <= 1'b0;
            res_dec_o    <= 1'b0;
            lop_decl_o   <= 1'b0;
            path_alarm_declared_decl_o  <= 1'b0;
            drop_ais_o   <= 1'b0;
            rdi_req_o    <= 1'b0;
            g1_rdi_o     <= 1'b0;
        end
        else
        begin
            res_valid_o  <= ptr_valid_i & slot_ok;
            res_slot_o   <= s;
            res_state_o  <= st_n;
            res_concatenated_state_o   <= concatenated_state;
            res_offset_o <= act_n;
            res_inc_o    <= ptr_valid_i & slot_ok & inc_n;
            res_dec_o    <= ptr_valid_i & slot_ok & dec_n;
            // declaration pulses on entry to each alarm state
            lop_decl_o   <= ptr_valid_i & slot_ok & enter_lop;
            path_alarm_declared_decl_o  <= ptr_valid_i & slot_ok & enter_ais;
            drop_ais_o   <= ptr_valid_i & slot_ok & ais_insert;
            // remote indication, local request or in-band G1 bit
            rdi_req_o    <= ptr_valid_i & slot_ok & in_alarm &
                            cfg_reg[`HOPI_CFG_RDI_REQ] &
                            ~cfg_reg[`HOPI_CFG_INBAND];
            g1_rdi_o     <= ptr_valid_i & slot_ok & in_alarm &
                            cfg_reg[`HOPI_CFG_INBAND];
        end
    end

    // wishbone decode
    wire       wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire       wb_wr  = wb_req & wb_we_i;
    wire [1:0] sel_st = st_mem[(sel_reg < 6'd48) ? sel_reg : 6'h00];
    wire [9:0] sel_of = act_mem[(sel_reg < 6'd48) ? sel_reg : 6'h00];

    // register writes honour byte lanes
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            cfg_reg     <= `HOPI_CFG_RST;
            concatenated_state_lo_reg <= 32'h00000000;
            concatenated_state_hi_reg <= 16'h0000;
            sel_reg     <= 6'h00;
        end
        else if (wb_wr)
        begin
            case (wb_adr_i)
                `HOPI_CFG_OFS:
                begin
                    if (wb_sel_i[0])
                        cfg_reg[7:0] <= wb_dat_i[7:0];
                    if (wb_sel_i[1])
                        cfg_reg[8] <= wb_dat_i[8];
                end
                `HOPI_CONCATENATED_STATE_LO_OFS:
                begin
                    for (j = 0; j < 4; j = j + 1)
                        if (wb_sel_i[j])
                            concatenated_state_lo_reg[j*8 +: 8] <= wb_dat_i[j*8 +: 8];
                end
                `HOPI_CONCATENATED_STATE_HI_OFS:
                begin
                    if (wb_sel_i[0])
                        concatenated_state_hi_reg[7:0] <= wb_dat_i[7:0];
                    if (wb_sel_i[1])
                        concatenated_state_hi_reg[15:8] <= wb_dat_i[15:8];
                end
                `HOPI_SEL_OFS:
                begin
                    if (wb_sel_i[0])
                        sel_reg <= wb_dat_i[5:0];
                end
                default:
                    sel_reg <= sel_reg;
            endcase
        end
    end

    // ack one cycle after the request; unmapped reads give zero
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end
        else
        begin
            wb_ack_o <= wb_req;
            wb_dat_o <= 32'h00000000;
            if (wb_req && !wb_we_i)
            begin
                case (wb_adr_i)
                    `HOPI_CFG_OFS:     wb_dat_o <= {23'h000000, cfg_reg};
                    `HOPI_CONCATENATED_STATE_LO_OFS: wb_dat_o <= concatenated_state_lo_reg;
                    `HOPI_CONCATENATED_STATE_HI_OFS: wb_dat_o <= {16'h0000, concatenated_state_hi_reg};
                    `HOPI_SEL_OFS:     wb_dat_o <= {26'h0000000, sel_reg};
                    `HOPI_STAT_OFS:    wb_dat_o <= {19'h00000, concatenated_state_map[sel_reg
                                                  < 6'd48 ? sel_reg : 6'h00],
                                                  sel_st, sel_of};
                    default:           wb_dat_o <= 32'h00000000;
                endcase
            end
        end
    end

endmodule // hopi_core
`default_nettype wire

// ---- testbench/hopi_monitor.sv ----
// checker on the pointer interpreter result and alarm ports
// assumes binding into hopi_core, one clock, synchronous reset
`timescale 1ns/100ps
`default_nettype none
module hopi_monitor
(
    // clock and reset
    input wire logic       clk_i,
    input wire logic       rst_i,
    // pointer stream
    input wire logic       ptr_valid_i,
    input wire logic [5:0] ptr_slot_i,
    input wire logic [7:0] ptr_h1_i,
    input wire logic [7:0] ptr_h2_i,
    // results and alarms
    input wire logic       res_valid_o,
    input wire logic [5:0] res_slot_o,
    input wire logic [1:0] res_state_o,
    input wire logic       res_concatenated_state_o,
    input wire logic       res_inc_o,
    input wire logic       res_dec_o,
    input wire logic       lop_decl_o,
    input wire logic       path_alarm_declared_decl_o,
    input wire logic       drop_ais_o,
    input wire logic       g1_rdi_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    property p_res; ptr_valid_i && ptr_slot_i < 6'd48 |=> res_valid_o
        && res_slot_o == $past(ptr_slot_i); endproperty
    a_res: assert property (p_res) else $error("result missing");
    property p_none; !ptr_valid_i || ptr_slot_i > 6'd47 |=> !res_valid_o;
    endproperty
    a_none: assert property (p_none) else $error("stray result");
    property p_lop; lop_decl_o |-> res_valid_o && res_state_o == 2'h2;
    endproperty
    a_lop: assert property (p_lop) else $error("loss flag bad");
    property p_path_alarm_declared; path_alarm_declared_decl_o |-> res_valid_o && (drop_ais_o ||
        res_concatenated_state_o) && res_state_o == 2'h1; endproperty
    a_path_alarm_declared: assert property (p_path_alarm_declared) else $error("alarm flag bad");
    property p_ones; ptr_valid_i && ptr_h1_i == 8'hff && ptr_h2_i == 8'hff
        |=> !res_inc_o && !res_dec_o && !lop_decl_o; endproperty
    a_ones: assert property (p_ones) else $error("all ones misread");
    property p_just; res_inc_o || res_dec_o |-> res_valid_o
        && res_state_o == 2'h0 && !(res_inc_o && res_dec_o); endproperty
    a_just: assert property (p_just) else $error("step bad");
    property p_rdi; g1_rdi_o |-> res_valid_o && res_state_o != 2'h0;
    endproperty
    a_rdi: assert property (p_rdi) else $error("rdi in normal");
    property p_one; lop_decl_o |-> !path_alarm_declared_decl_o; endproperty
    a_one: assert property (p_one) else $error("two entries");
endmodule // hopi_monitor
bind hopi_core hopi_monitor u_mon (.*);
`default_nettype wire

// ---- testbench/hopi_src.sv ----
// upstream model: hands one H1/H2 pair per call to the interpreter
// assumes the caller keeps one pointer per slot per frame
`timescale 1ns/100ps
`default_nettype none
module hopi_src
(
    // clock
    input  wire logic       clk_i,
    // pointer stream
    output var  logic       ptr_valid_o,
    output var  logic [5:0] ptr_slot_o,
    output var  logic [7:0] ptr_h1_o,
    output var  logic [7:0] ptr_h2_o
);
    initial {ptr_valid_o, ptr_slot_o, ptr_h1_o, ptr_h2_o} = '0;
    // one-cycle valid; released lines show the inverse, not stale data
    task automatic send(input logic [5:0] s, input logic [7:0] a, b);
        @(posedge clk_i);
        {ptr_valid_o, ptr_slot_o, ptr_h1_o, ptr_h2_o} <= {1'b1, s, a, b};
        @(posedge clk_i);
        {ptr_valid_o, ptr_slot_o, ptr_h1_o, ptr_h2_o} <= {1'b0, ~s, ~a, ~b};
    endtask
endmodule // hopi_src
`default_nettype wire

// ---- testbench/test_hopi_core.sv ----
// bench for hopi_core: pointers via the upstream model, registers via
// wishbone, each ptr result checked against a per-slot model
// assumes hopi_core, hopi_src and the checker are compiled first
`timescale 1ns/100ps
`default_nettype none
module test_hopi_core;
    logic        clk_i = 0, rst_i = 1, wb_cyc_i = 0, wb_stb_i = 0;
    logic        wb_we_i = 0;
    logic [7:0]  wb_adr_i = 0;
    logic [3:0]  wb_sel_i = 4'hf;
    logic [31:0] wb_dat_i = 0, exp;
    wire  [31:0] wb_dat_o;
    wire  [9:0]  res_offset_o;
    wire  [7:0]  ptr_h1_i, ptr_h2_i;
    wire  [5:0]  ptr_slot_i, res_slot_o;
    wire  [1:0]  res_state_o;
    wire wb_ack_o, ptr_valid_i, res_valid_o, res_concatenated_state_o, res_inc_o, res_dec_o;
    wire lop_decl_o, path_alarm_declared_decl_o, drop_ais_o, rdi_req_o, g1_rdi_o;
    int mismatches = 0, checked = 0, cfg = 'h60;
    int st[48] = '{default: 2}, ag[48] = '{default: 4};
    int of[48], ci[48], cn[48], ca[48], ce[48], ev[48];
    int dc[5] = '{6, 14, 2, 4, 7}, ec[5] = '{9, 1, 13, 11, 8};
    int ic[6] = '{0, 3, 5, 10, 12, 15};
    hopi_core u_dut (.*);
    hopi_src u_src (.clk_i(clk_i), .ptr_valid_o(ptr_valid_i),
        .ptr_slot_o(ptr_slot_i), .ptr_h1_o(ptr_h1_i), .ptr_h2_o(ptr_h2_i));
    always #5 clk_i = ~clk_i;
    task automatic chk(input logic [31:0] seen, input logic [31:0] want);
        checked++;
        if (seen !== want)
        begin
            mismatches++;
            $display("ERROR t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask
    task automatic end_sim;
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // classic single cycle, held until ack is sampled high
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] q);
        @(posedge clk_i);
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'h3, w, a, d};
        @(posedge clk_i);
        while (wb_ack_o !== 1'b1) @(posedge clk_i);
        q = wb_dat_o;
        {wb_cyc_i, wb_stb_i} <= 2'h0;
    endtask
    // per-slot reference: classify, count, move state, expect outputs
    task automatic model(input int s, input int h1, input int h2);
        int n, o, en, di, ai, ij, dj, nw, ok, nx;
        n = h1 >> 4;
        o = (h1 % 4) * 256 + h2;
        en = n inside {9, 1, 13, 11, 8};
        di = n inside {6, 14, 2, 4, 7};
        ai = h1 == 255 && h2 == 255;
        ij = di && (ag[s] > 3 || cfg[2]) && $countones((o ^ of[s]) & 'h2aa)
            > 2 && $countones((o ^ of[s]) & 'h155) < 3;
        dj = di && (ag[s] > 3 || cfg[2]) && $countones((o ^ of[s]) & 'h155)
            > 2 && $countones((o ^ of[s]) & 'h2aa) < 3;
        nw = di && o <= 782 && o != of[s] && !ij && !dj;
        ok = di && o == of[s] || en && o <= 782 || ai || ij || dj;
        ce[s] = nw ? (ev[s] == o ? ce[s] + 1 : 1) : 0;
        ev[s] = o;
        ca[s] = ai ? ca[s] + 1 : 0;
        cn[s] = en && o <= 782 && st[s] == 0 ? cn[s] + 1 : 0;
        ci[s] = nw || !ok ? ci[s] + 1 : 0;
        ag[s] = en && o <= 782 || ij || dj ? 0 : ag[s] + 1;
        nx = st[s];
        if (ce[s] == 3 || st[s] == 1 && en && o <= 782)
        begin
            nx = 0;
            of[s] = o;
        end
        else if (ca[s] == 3)
            nx = 1;
        else if (ci[s] == 8 || cn[s] == 8)
            nx = 2;
        else if (st[s] == 0)
            of[s] = en && o <= 782 ? o : ij ? (of[s] + 1) % 783 :
                dj ? (of[s] + 782) % 783 : of[s];
        if (nx != st[s])
            {ce[s], ca[s], cn[s]} = '0;
        exp = {1'b1, 6'(s), 2'(nx), 1'b0, 10'(of[s]), 1'(ij), 1'(dj),
            nx == 2 && st[s] != 2, nx == 1 && st[s] != 1, nx == 1 ||
            nx == 2 && cfg[5], nx != 0 && cfg[6] && !cfg[7], nx != 0 && cfg[7]};
        st[s] = nx;
    endtask
    task automatic ptr(input int s, input int h1, input int h2);
        u_src.send(6'(s), 8'(h1), 8'(h2));
        model(s, h1, h2);
        @(posedge clk_i);
        chk({res_valid_o, res_slot_o, res_state_o, res_concatenated_state_o, res_offset_o,
            res_inc_o, res_dec_o, lop_decl_o, path_alarm_declared_decl_o, drop_ais_o,
            rdi_req_o, g1_rdi_o}, exp); // result record
    endtask
    // main sequence
    initial
    begin
        int r, s, i;
        logic [31:0] q;
        r = $urandom(31);
        s = 2 + $urandom % 46;
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        bus(1, 8'h00, cfg, q);
        bus(0, 8'h00, 0, q);
        chk(q, 32'h60);
        bus(1, 8'h0c, s, q);
        bus(0, 8'h10, 0, q);
        chk(q, 32'h800);
        bus(0, 8'h40, 0, q);
        chk(q, 0);
        for (i = 0; i < 3; i++) ptr(s, 'h60, 100);
        for (i = 0; i < 5; i++) ptr(s, dc[i] << 4, 100);
        ptr(s, 'h62, 'hce);
        ptr(s, 'h61, 'h30);
        for (i = 0; i < 4; i++) ptr(s, 'h60, 101);
        ptr(s, 'h61, 'h30);
        for (i = 0; i < 3; i++) ptr(s, 'hff, 'hff);
        ptr(s, 'h90, 200);
        for (i = 0; i < 8; i++) ptr(s, ec[i % 5] << 4, 200);
        u_src.send(6'(48 + $urandom % 16), 8'h60, 8'h01);
        @(posedge clk_i);
        chk(res_valid_o, 0);
        cfg = 'he0;
        bus(1, 8'h00, cfg, q);
        for (i = 0; i < 4; i++) ptr(s - 1, 'h61, 'h2c);
        for (i = 0; i < 8; i++) ptr(s - 1, ic[i % 6] << 4 | 1, 'h2c);
        bus(0, 8'h10, 0, q);
        chk(q, 32'h8c8);
        // slot 0 as a concatenation slot: alarm, then back to normal
        bus(1, 8'h04, 1, q);
        for (i = 0; i < 3; i++) u_src.send(6'h00, 8'hff, 8'hff);
        @(posedge clk_i);
        chk({res_valid_o, res_concatenated_state_o, res_state_o, path_alarm_declared_decl_o, g1_rdi_o},
            6'b110111);
        for (i = 0; i < 3; i++) u_src.send(6'h00, 8'h97, 8'hff);
        @(posedge clk_i);
        chk({res_valid_o, res_concatenated_state_o, res_state_o, lop_decl_o, g1_rdi_o},
            6'b110000);
        end_sim;
    end
    // watchdog against a hung handshake
    initial
    begin
        repeat (5000) @(posedge clk_i);
        mismatches++;
        end_sim;
    end
endmodule // test_hopi_core
`default_nettype wire
